// >>> design/cmpx_map.svh
/*
 * Offsets, field positions, reset values and status codes of the compare
 * command block. Assumes word-aligned byte addresses on a 32-bit bus.
 */
`ifndef CMPX_MAP_SVH
`define CMPX_MAP_SVH

// ==========================================================
// Register byte offsets
`define CMPX_OFS_CTRL    8'h00
`define CMPX_OFS_STAT    8'h04
`define CMPX_OFS_MD_LO   8'h08
`define CMPX_OFS_MD_HI   8'h0C
`define CMPX_OFS_DP1_LO  8'h10
`define CMPX_OFS_DP1_HI  8'h14
`define CMPX_OFS_DP2_LO  8'h18
`define CMPX_OFS_DP2_HI  8'h1C
`define CMPX_OFS_CDW10   8'h20
`define CMPX_OFS_CDW11   8'h24
`define CMPX_OFS_CDW12   8'h28
`define CMPX_OFS_CDW14   8'h2C
`define CMPX_OFS_CDW15   8'h30
`define CMPX_OFS_BLKS    8'h34

// ==========================================================
// Field positions
`define CMPX_CTL_START   0
`define CMPX_CTL_PIEN    1
`define CMPX_CTL_MDP     2
`define CMPX_STAT_DONE   1
`define CMPX_D12_LR      31
`define CMPX_D12_FUA     30
`define CMPX_D12_PI_HI   29
`define CMPX_D12_PI_LO   26

// ==========================================================
// Reset values, sizes and status codes
`define CMPX_RST_WORD    32'h0000_0000
`define CMPX_BLK_BYTES   512
`define CMPX_PAGE_BYTES  4096
`define CMPX_SCT_GEN     3'h0
`define CMPX_SCT_CMD     3'h1
`define CMPX_SCT_MEDIA   3'h2
`define CMPX_SC_OK       8'h00
`define CMPX_SC_BAD_PI   8'h81
`define CMPX_SC_CMP_FAIL 8'h85
`define CMPX_SC_GUARD    8'h82
`define CMPX_SC_APP      8'h83
`define CMPX_SC_REF      8'h84

`endif

// >>> design/cmpx_pkg.sv
/*
 * Types of the compare command block: beats, requests, completions, state.
 * Assumes the media engine delivers media and host words side by side.
 */
package cmpx_pkg;

    // ==========================================================
    // Enumerations
    typedef enum logic [1:0] {
        CMPX_IDLE = 2'b00,
        CMPX_RUN  = 2'b01,
        CMPX_CPL  = 2'b10
    } cmpx_fsm_t;

    typedef enum logic [1:0] {
        CMPX_K_DATA = 2'b00,  // Block data word
        CMPX_K_META = 2'b01,  // Plain metadata word
        CMPX_K_TAGS = 2'b10,  // Guard [31:16], app tag [15:0]
        CMPX_K_REF  = 2'b11   // Reference tag
    } cmpx_kind_t;

    typedef enum logic [1:0] {
        CMPX_DP2_RSVD = 2'b00,
        CMPX_DP2_BUF  = 2'b01,
        CMPX_DP2_LIST = 2'b10
    } cmpx_dp2_t;

    // ==========================================================
    // Carriers
    typedef struct packed {
        cmpx_kind_t  kind;
        logic [31:0] media;
        logic [31:0] host;
        logic        last;
    } cmpx_beat_t;

    typedef struct packed {
        logic [63:0] lba;
        logic [16:0] blocks;
        logic        force_media_access;
        logic        limited_retry;
        logic        pi_action;
        logic [63:0] md_ptr;
        logic [63:0] dp1;
        logic [63:0] dp2;
        cmpx_dp2_t   dp2_mode;
    } cmpx_req_t;

    typedef struct packed {
        logic [15:0] sq_id;
        logic [2:0]  sct;
        logic [7:0]  sc;
    } cmpx_cpl_t;

    typedef struct packed {
        cmpx_fsm_t   fsm;
        logic [63:0] md_ptr;
        logic [63:0] dp1;
        logic [63:0] dp2;
        logic [31:0] cdw10;
        logic [31:0] cdw11;
        logic [31:0] cdw12;
        logic [31:0] cdw14;
        logic [31:0] cdw15;
        logic        ns_pi_en;
        logic        md_present;
        logic [15:0] sq_id;
        logic [15:0] blk_cnt;
        logic [31:0] exp_ref;
        logic        guard_fail;
        logic        app_fail;
        logic        ref_fail;
        logic        cmp_fail;
        logic        done;
        logic        wr_pend;
        logic [7:0]  wr_addr;
        logic [31:0] hrdata;
        logic        req_valid;
        cmpx_req_t   req;
        cmpx_cpl_t   cpl;
    } cmpx_st_t;

endpackage : cmpx_pkg

// >>> design/cmpx_word_cmp.sv
/*
 * Byte-wise comparison of a media word against a host word.
 * Assumes both words are aligned to the same byte lanes.
 */
`timescale 1ns/1ps
module cmpx_word_cmp #(
    parameter int NBYTES = 4
) (
    input  wire logic [8*NBYTES-1:0] media,     // Word read from media
    input  wire logic [8*NBYTES-1:0] host,      // Word from host buffer
    output logic      [NBYTES-1:0]   byte_diff, // Per-lane difference
    output logic                     mismatch   // Any lane differs
);
    // ==========================================================
    // One comparator per byte lane
    genvar i;
    generate
        for (i = 0; i < NBYTES; i++) begin : g_lane
            assign byte_diff[i] = media[8*i +: 8] != host[8*i +: 8];
        end
    endgenerate

    // Reduction over lanes
    assign mismatch = |byte_diff;
endmodule : cmpx_word_cmp

// >>> design/cmpx_pi_check.sv
/*
 * Tag comparison of one protection tuple.
 * Assumes the guard expected value arrives precomputed in the host word.
 */
`timescale 1ns/1ps
module cmpx_pi_check (
    input  wire logic [31:0] media,     // Guard and app tag, or ref tag
    input  wire logic [15:0] exp_guard, // Expected guard
    input  wire logic [15:0] exp_app,   // Expected application tag
    input  wire logic [15:0] app_mask,  // Application tag mask
    input  wire logic [31:0] exp_ref,   // Expected reference tag
    output logic             guard_mis, // Guard differs
    output logic             app_mis,   // Masked app tag differs
    output logic             ref_mis    // Reference tag differs
);
    // ==========================================================
    // Field comparators; the mask limits which app tag bits count
    assign guard_mis = media[31:16] != exp_guard;
    assign app_mis   = ((media[15:0] ^ exp_app) & app_mask) != 16'h0000;
    assign ref_mis   = media != exp_ref;
endmodule : cmpx_pi_check

// >>> design/cmpx_top.sv
/*
 * Compare command executor with protection information checking, reached
 * over AHB-Lite. Assumes a media engine that takes req and streams beats.
 */
// The register addresses and the AHB-Lite interface to the registers are this design's own decisions.
// Notes on behaviour
// R1: action bit strips PI, else passes it
// R2: PI fields ignored without PI namespace
// R3: check bit 2 enables guard check
// R4: check bit 1 enables app tag check
// R5: check bit 0 enables ref tag check
// R6: success only when every byte matches
// R7: any difference completes with compare failure
// R8: supplied metadata also compared
// R9: host gives dword-aligned contiguous metadata buffer
// R10: second pointer reserved, buffer, or list
// R11: start address from dwords 10 and 11
// R12: limited retry bit selects recovery effort
// R13: force media access bypasses volatile cache
// R14: protection field is dword 12 bits 29:26
// R15: zero-based block count, compare count plus one
// R16: dword 14 is initial reference tag
// R17: dword 15 holds app tag mask, tag
// R18: completion carries status and queue
// R19: invalid protection settings give status 81h
// R20: host keeps unused fields reserved
// R21: host may request limited retry recovery
// R22: host buffers ready before command posted
`timescale 1ns/1ps
`include "cmpx_map.svh"
module cmpx_top #(
    parameter int BLK_BYTES  = `CMPX_BLK_BYTES,
    parameter int PAGE_BYTES = `CMPX_PAGE_BYTES
) (
    input  wire logic                 hclk,      // Bus clock, 20 MHz
    input  wire logic                 hresetn,   // Async reset, active low
    input  wire logic                 ce,        // Clock enable
    input  wire logic                 hsel,      // Slave select
    input  wire logic [31:0]          haddr,     // Byte address
    input  wire logic [1:0]           htrans,    // Transfer type
    input  wire logic                 hwrite,    // Write access
    input  wire logic [2:0]           hsize,     // Word only
    input  wire logic [31:0]          hwdata,    // Write data
    input  wire logic                 hready,    // Bus ready
    output logic      [31:0]          hrdata,    // Read data
    output logic                      hreadyout, // Slave ready
    output logic                      hresp,     // Always OKAY
    input  wire logic                 in_valid,  // Beat offered
    output logic                      in_ready,  // Beat taken
    input  wire cmpx_pkg::cmpx_beat_t in_beat,   // Media and host words
    output logic                      req_valid, // One-cycle read request
    output cmpx_pkg::cmpx_req_t       req,       // Read request fields
    output logic                      cpl_valid, // Completion pending
    input  wire logic                 cpl_ready, // Completion posted
    output cmpx_pkg::cmpx_cpl_t       cpl        // Completion entry
);
    // ==========================================================
    // State and decoded command fields
    cmpx_pkg::cmpx_st_t s;
    cmpx_pkg::cmpx_st_t next_s;
    logic [3:0]         pi_eff;
    logic               bus_go;
    logic               start;
    logic               pi_bad;
    logic               data_mis;
    logic               guard_mis;
    logic               app_mis;
    logic               ref_mis;
    logic               in_fire;
    logic [31:0]        rd_mux;
    logic [31:0]        xfer_bytes;
    logic [31:0]        first_room;

    // Protection fields count only on a PI-formatted namespace
    assign pi_eff  = s.ns_pi_en ? s.cdw12[`CMPX_D12_PI_HI:`CMPX_D12_PI_LO] : 4'h0; // R2 R14
    assign in_fire = in_valid && in_ready;
    assign bus_go  = hsel && htrans[1] && hready;
    assign start   = s.wr_pend && s.wr_addr == `CMPX_OFS_CTRL && hwdata[`CMPX_CTL_START]
                     && s.fsm == cmpx_pkg::CMPX_IDLE;
    // App tag check with an all-zero mask can never test anything
    assign pi_bad  = hwdata[`CMPX_CTL_PIEN] && s.cdw12[27] && s.cdw15[31:16] == 16'h0000; // R19

    // Sizing of the second data pointer's role
    assign xfer_bytes = (32'(s.cdw12[15:0]) + 32'h1) * 32'(BLK_BYTES);
    assign first_room = 32'(PAGE_BYTES) - (s.dp1[31:0] & 32'(PAGE_BYTES - 1));

    // ==========================================================
    // Comparators
    cmpx_word_cmp #(.NBYTES(4)) u_cmp (
        .media     (in_beat.media),
        .host      (in_beat.host),
        .byte_diff (),
        .mismatch  (data_mis)
    );

    cmpx_pi_check u_pi (
        .media     (in_beat.media),
        .exp_guard (in_beat.host[31:16]),
        .exp_app   (s.cdw15[15:0]),
        .app_mask  (s.cdw15[31:16]),
        .exp_ref   (s.exp_ref),
        .guard_mis (guard_mis),
        .app_mis   (app_mis),
        .ref_mis   (ref_mis)
    );

    // ==========================================================
    // Register read mux, sampled in the address phase
    always_comb begin
        unique case (haddr[7:0])
            `CMPX_OFS_CTRL:   rd_mux = {s.sq_id, 13'h0, s.md_present, s.ns_pi_en, 1'b0};
            `CMPX_OFS_STAT:   rd_mux = {13'h0, s.cpl.sct, s.cpl.sc, 6'h0, s.done,
                                        s.fsm != cmpx_pkg::CMPX_IDLE};
            `CMPX_OFS_MD_LO:  rd_mux = s.md_ptr[31:0];
            `CMPX_OFS_MD_HI:  rd_mux = s.md_ptr[63:32];
            `CMPX_OFS_DP1_LO: rd_mux = s.dp1[31:0];
            `CMPX_OFS_DP1_HI: rd_mux = s.dp1[63:32];
            `CMPX_OFS_DP2_LO: rd_mux = s.dp2[31:0];
            `CMPX_OFS_DP2_HI: rd_mux = s.dp2[63:32];
            `CMPX_OFS_CDW10:  rd_mux = s.cdw10;
            `CMPX_OFS_CDW11:  rd_mux = s.cdw11;
            `CMPX_OFS_CDW12:  rd_mux = s.cdw12;
            `CMPX_OFS_CDW14:  rd_mux = s.cdw14;
            `CMPX_OFS_CDW15:  rd_mux = s.cdw15;
            `CMPX_OFS_BLKS:   rd_mux = {16'h0, s.blk_cnt};
            default:          rd_mux = 32'h0000_0000;
        endcase
    end

    // ==========================================================
    // Next-state logic: bus, command start, beat checking, completion
    always_comb begin
        next_s           = s;
        next_s.req_valid = 1'b0;
        next_s.wr_pend   = bus_go && hwrite;
        if (bus_go) begin
            next_s.wr_addr = haddr[7:0];
            next_s.hrdata  = hwrite ? 32'h0000_0000 : rd_mux;
        end
        // Command words are frozen while a compare is in flight
        if (s.wr_pend) begin
            if (s.wr_addr == `CMPX_OFS_STAT && hwdata[`CMPX_STAT_DONE]) begin
                next_s.done = 1'b0;
            end
            if (s.fsm == cmpx_pkg::CMPX_IDLE) begin
                case (s.wr_addr)
                    `CMPX_OFS_CTRL: begin
                        next_s.sq_id      = hwdata[31:16];
                        next_s.md_present = hwdata[`CMPX_CTL_MDP];
                        next_s.ns_pi_en   = hwdata[`CMPX_CTL_PIEN];
                    end
                    `CMPX_OFS_MD_LO:  next_s.md_ptr[31:0]  = {hwdata[31:2], 2'b00}; // R9
                    `CMPX_OFS_MD_HI:  next_s.md_ptr[63:32] = hwdata;
                    `CMPX_OFS_DP1_LO: next_s.dp1[31:0]     = hwdata;
                    `CMPX_OFS_DP1_HI: next_s.dp1[63:32]    = hwdata;
                    `CMPX_OFS_DP2_LO: next_s.dp2[31:0]     = hwdata;
                    `CMPX_OFS_DP2_HI: next_s.dp2[63:32]    = hwdata;
                    `CMPX_OFS_CDW10:  next_s.cdw10         = hwdata;
                    `CMPX_OFS_CDW11:  next_s.cdw11         = hwdata;
                    `CMPX_OFS_CDW12:  next_s.cdw12         = hwdata;
                    `CMPX_OFS_CDW14:  next_s.cdw14         = hwdata;
                    `CMPX_OFS_CDW15:  next_s.cdw15         = hwdata;
                    default: ;
                endcase
            end
        end
        unique case (s.fsm)
            cmpx_pkg::CMPX_IDLE: begin
                if (start && pi_bad) begin
                    next_s.fsm = cmpx_pkg::CMPX_CPL;
                    next_s.cpl = {hwdata[31:16], `CMPX_SCT_CMD, `CMPX_SC_BAD_PI}; // R19 R18
                end else if (start) begin
                    next_s.fsm                = cmpx_pkg::CMPX_RUN;
                    next_s.req_valid          = 1'b1;
                    next_s.req.lba            = {s.cdw11, s.cdw10}; // R11
                    next_s.req.blocks         = 17'(s.cdw12[15:0]) + 17'h1; // R15
                    next_s.req.limited_retry  = s.cdw12[`CMPX_D12_LR]; // R12
                    next_s.req.force_media_access            = s.cdw12[`CMPX_D12_FUA]; // R13
                    next_s.req.pi_action      = hwdata[`CMPX_CTL_PIEN]
                                                && s.cdw12[`CMPX_D12_PI_HI]; // R1 R2
                    next_s.req.md_ptr         = s.md_ptr;
                    next_s.req.dp1            = s.dp1;
                    next_s.req.dp2            = s.dp2;
                    // Second pointer is unused, a buffer, or a list
                    if (xfer_bytes <= first_room) begin
                        next_s.req.dp2_mode = cmpx_pkg::CMPX_DP2_RSVD; // R10
                    end else if (xfer_bytes - first_room <= 32'(PAGE_BYTES)) begin
                        next_s.req.dp2_mode = cmpx_pkg::CMPX_DP2_BUF; // R10
                    end else begin
                        next_s.req.dp2_mode = cmpx_pkg::CMPX_DP2_LIST; // R10
                    end
                    next_s.blk_cnt    = 16'h0000;
                    next_s.exp_ref    = s.cdw14; // R16
                    next_s.guard_fail = 1'b0;
                    next_s.app_fail   = 1'b0;
                    next_s.ref_fail   = 1'b0;
                    next_s.cmp_fail   = 1'b0;
                end
            end
            cmpx_pkg::CMPX_RUN: begin
                if (in_fire) begin
                    unique case (in_beat.kind)
                        cmpx_pkg::CMPX_K_DATA: begin
                            if (data_mis) next_s.cmp_fail = 1'b1; // R6 R7
                        end
                        cmpx_pkg::CMPX_K_META: begin
                            if (s.md_present && data_mis) next_s.cmp_fail = 1'b1; // R8
                        end
                        cmpx_pkg::CMPX_K_TAGS: begin
                            if (pi_eff[2] && guard_mis) next_s.guard_fail = 1'b1; // R3
                            if (pi_eff[1] && app_mis) next_s.app_fail = 1'b1; // R4 R17
                            // Stripped PI never reaches the host buffer
                            if (!pi_eff[3] && s.md_present && data_mis) begin
                                next_s.cmp_fail = 1'b1; // R1 R8
                            end
                        end
                        cmpx_pkg::CMPX_K_REF: begin
                            if (pi_eff[0] && ref_mis) next_s.ref_fail = 1'b1; // R5 R16
                            if (!pi_eff[3] && s.md_present && data_mis) begin
                                next_s.cmp_fail = 1'b1; // R1 R8
                            end
                        end
                    endcase
                    if (in_beat.last) begin
                        next_s.blk_cnt = s.blk_cnt + 16'h0001;
                        next_s.exp_ref = s.exp_ref + 32'h0000_0001;
                        if (s.blk_cnt == s.cdw12[15:0]) begin // R15
                            next_s.fsm = cmpx_pkg::CMPX_CPL;
                            // Protection errors outrank a plain mismatch
                            if (next_s.guard_fail) begin
                                next_s.cpl = {s.sq_id, `CMPX_SCT_MEDIA, `CMPX_SC_GUARD};
                            end else if (next_s.app_fail) begin
                                next_s.cpl = {s.sq_id, `CMPX_SCT_MEDIA, `CMPX_SC_APP};
                            end else if (next_s.ref_fail) begin
                                next_s.cpl = {s.sq_id, `CMPX_SCT_MEDIA, `CMPX_SC_REF};
                            end else if (next_s.cmp_fail) begin
                                next_s.cpl = {s.sq_id, `CMPX_SCT_MEDIA, `CMPX_SC_CMP_FAIL}; // R7
                            end else begin
                                next_s.cpl = {s.sq_id, `CMPX_SCT_GEN, `CMPX_SC_OK}; // R6
                            end
                        end
                    end
                end
            end
            cmpx_pkg::CMPX_CPL: begin
                // Done is set after the clear above, so a set wins
                if (cpl_ready) begin
                    next_s.fsm  = cmpx_pkg::CMPX_IDLE;
                    next_s.done = 1'b1; // R18
                end
            end
            default: next_s.fsm = cmpx_pkg::CMPX_IDLE;
        endcase
    end

    // ==========================================================
    // State register; clock enable freezes everything
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    // ==========================================================
    // Outputs
    assign hrdata    = s.hrdata;
    assign hreadyout = ce;
    assign hresp     = 1'b0;
    assign in_ready  = ce && s.fsm == cmpx_pkg::CMPX_RUN;
    assign req_valid = s.req_valid;
    assign req       = s.req;
    assign cpl_valid = s.fsm == cmpx_pkg::CMPX_CPL;
    assign cpl       = s.cpl;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    strip_pass_a: assert property (req_valid |-> req.pi_action == (s.ns_pi_en && s.cdw12[29])) // R1
        else $error("pi action not honoured");
    pi_ignore_a: assert property (ce && in_fire && !s.ns_pi_en && !s.ref_fail |=> !s.ref_fail) // R2
        else $error("tag checked on plain namespace");
    guard_check_a: assert property (ce && in_fire && in_beat.kind == cmpx_pkg::CMPX_K_TAGS // R3
        && pi_eff[2] && guard_mis |=> s.guard_fail) else $error("guard error missed");
    app_check_a: assert property (ce && in_fire && in_beat.kind == cmpx_pkg::CMPX_K_TAGS // R4
        && !pi_eff[1] && !s.app_fail |=> !s.app_fail) else $error("app tag checked unasked");
    ref_check_a: assert property (ce && in_fire && in_beat.kind == cmpx_pkg::CMPX_K_REF // R5
        && pi_eff[0] && ref_mis |=> s.ref_fail) else $error("ref tag error missed");
    mismatch_fail_a: assert property (ce && in_fire && in_beat.kind == cmpx_pkg::CMPX_K_DATA // R7
        && data_mis |=> s.cmp_fail) else $error("data mismatch lost");
    start_lba_a: assert property (req_valid |-> req.lba == {s.cdw11, s.cdw10}) // R11
        else $error("start address wrong");
    block_count_a: assert property (req_valid |-> req.blocks == 17'(s.cdw12[15:0]) + 17'h1) // R15
        else $error("block count wrong");
    bad_pi_a: assert property (ce && start && pi_bad // R19
        |=> cpl_valid && cpl.sc == 8'h81 && cpl.sct == 3'h1) else $error("81h not reported");
    cpl_hold_a: assert property (cpl_valid && !cpl_ready |=> cpl_valid && $stable(cpl)) // R18
        else $error("completion dropped");

    ok_cpl_c: cover property (cpl_valid && cpl_ready && cpl.sc == 8'h00);
    fail_cpl_c: cover property (cpl_valid && cpl_ready && cpl.sc == 8'h85);
    guard_cpl_c: cover property (cpl_valid && cpl.sc == 8'h82);
    bad_pi_c: cover property (ce && start && pi_bad);
endmodule : cmpx_top

// >>> tb/cmpx_media_model.sv
/* Media engine model: data, tag and ref beats per block after a request.
   Assumes req_valid pulses once per started compare. */
`timescale 1ns/1ps
module cmpx_media_model (
    input  wire logic                hclk,      // Clock
    input  wire logic                hresetn,   // Async reset
    input  wire logic                req_valid, // Compare started
    input  wire cmpx_pkg::cmpx_req_t req,       // Block count
    input  wire logic                in_ready,  // Beat taken
    input  wire logic                bad_data,  // Corrupt data word
    input  wire logic                bad_guard, // Corrupt guard
    input  wire logic                slow,      // Gap after each beat
    input  wire logic [31:0]         ref_base,  // Initial ref tag
    output logic                     in_valid,  // Beat offered
    output cmpx_pkg::cmpx_beat_t     in_beat    // Beat content
);
    logic [16:0]          left;
    logic [15:0]          blk;
    logic [1:0]           k;
    cmpx_pkg::cmpx_beat_t b;
    // ==========================================================
    // Beat content; an idle bus shows the inverse, never stale data
    always_comb begin
        case (k)
            2'd0: b = '{cmpx_pkg::CMPX_K_DATA, 32'h1234_5678 + blk,
                        (32'h1234_5678 + blk) ^ {31'h0, bad_data}, 1'b0};
            2'd1: b = '{cmpx_pkg::CMPX_K_TAGS, 32'hA5A5_0042,
                        {16'hA5A5 ^ {15'h0, bad_guard}, 16'h0042}, 1'b0};
            default: b = '{cmpx_pkg::CMPX_K_REF, ref_base + blk, 32'h0, 1'b1};
        endcase
        in_beat = in_valid ? b : ~b;
    end
    // Beats only after the request, so host buffers are in place first
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            in_valid <= 1'b0;
            left <= '0;
            blk <= '0;
            k <= '0;
        end else if (req_valid) begin
            left <= req.blocks;
            blk <= '0;
            k <= '0;
            in_valid <= 1'b1;
        end else if (in_valid && in_ready) begin
            k <= (k == 2'd2) ? 2'd0 : k + 2'd1;
            blk <= blk + {15'h0, k == 2'd2};
            left <= left - {16'h0, k == 2'd2};
            in_valid <= !slow && !(k == 2'd2 && left == 17'd1);
        end else if (left != 17'd0) begin
            in_valid <= 1'b1;
        end
    end
endmodule : cmpx_media_model

// >>> tb/cmpx_top_bench.sv
/* Testbench of the compare block: AHB-Lite master and status checks.
   Assumes zero-wait slave and the media model beside it. */
`timescale 1ns/1ps
module cmpx_top_bench;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, cpl_ready, cpl_valid;
    logic in_valid, in_ready, req_valid, bad_data, bad_guard, slow;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    cmpx_pkg::cmpx_beat_t in_beat;
    cmpx_pkg::cmpx_req_t req, rq;
    cmpx_pkg::cmpx_cpl_t cpl;
    int mismatches, cmp_count;
    localparam logic [31:0] REF0 = 32'h0000_1000;
    localparam logic [31:0] TAG = 32'hFFFF_0042;
    assign hready = hreadyout;
    cmpx_top i_dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .in_valid(in_valid),
        .in_ready(in_ready), .in_beat(in_beat), .req_valid(req_valid), .req(req),
        .cpl_valid(cpl_valid), .cpl_ready(cpl_ready), .cpl(cpl));
    cmpx_media_model i_media (.hclk(hclk), .hresetn(hresetn), .req_valid(req_valid),
        .req(req), .in_ready(in_ready), .bad_data(bad_data), .bad_guard(bad_guard),
        .slow(slow), .ref_base(REF0), .in_valid(in_valid), .in_beat(in_beat));
    // Keep the last issued request for later comparison
    always @(posedge hclk) if (req_valid === 1'b1) rq <= req;
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_sim;
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim
    // Single transfer; hold each phase until hready is seen high
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : ahb
    // Program, start, await completion, post it, clear done
    task automatic cmd(input logic [31:0] ctl, c12, c15, input logic bd, bg,
                       input logic [10:0] exp);
        bad_data <= bd;
        bad_guard <= bg;
        ahb(1'b1, 8'h20, 32'h89AB_CDEF);
        ahb(1'b1, 8'h24, 32'h0000_0012);
        ahb(1'b1, 8'h28, c12);
        ahb(1'b1, 8'h2C, REF0);
        ahb(1'b1, 8'h30, c15);
        ahb(1'b1, 8'h00, ctl | 32'h1);
        for (int i = 0; i < 300 && cpl_valid !== 1'b1; i++) @(negedge hclk);
        check({53'h0, cpl.sct, cpl.sc}, {53'h0, exp});
        check({48'h0, cpl.sq_id}, {48'h0, ctl[31:16]});
        @(posedge hclk) cpl_ready <= 1'b1;
        @(posedge hclk) cpl_ready <= 1'b0;
        ahb(1'b0, 8'h04, 32'h0);
        check({63'h0, rd[1]}, 64'h1);
        ahb(1'b1, 8'h04, 32'h2);
    endtask : cmd
    task automatic t_regs;
        ahb(1'b0, 8'h80, 32'h0);
        check({32'h0, rd}, 64'h0);
        ahb(1'b1, 8'h08, 32'h0000_1003);
        ahb(1'b0, 8'h08, 32'h0);
        check({32'h0, rd}, 64'h1000);
    endtask : t_regs
    task automatic t_match;
        cmd(32'h0007_0000, 32'hC000_0001, TAG, 1'b0, 1'b0, 11'h000);
        check(rq.lba, 64'h0000_0012_89AB_CDEF);
        check({47'h0, rq.blocks}, 64'h2);
        check({62'h0, rq.force_media_access, rq.limited_retry}, 64'h3);
    endtask : t_match
    task automatic t_mismatch;
        slow <= 1'b1;
        cmd(32'h0003_0000, 32'h0000_0002, TAG, 1'b1, 1'b0, {3'h2, 8'h85});
        slow <= 1'b0;
    endtask : t_mismatch
    task automatic t_guard;
        cmd(32'h0005_0002, 32'h3400_0001, TAG, 1'b0, 1'b1, {3'h2, 8'h82});
        check({63'h0, rq.pi_action}, 64'h1);
        cmd(32'h0005_0000, 32'h3400_0001, TAG, 1'b0, 1'b1, 11'h000);
        cmd(32'h0005_0002, 32'h0C00_0001, TAG, 1'b0, 1'b0, 11'h000);
    endtask : t_guard
    task automatic t_badpi;
        cmd(32'h0009_0002, 32'h0800_0000, 32'h0000_0042, 1'b0, 1'b0, {3'h1, 8'h81});
    endtask : t_badpi
    initial begin
        {hresetn, hsel, hwrite, cpl_ready, bad_data, bad_guard, slow} = '0;
        {haddr, hwdata, htrans} = '0;
        hsize = 3'h2;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs;
        t_match;
        t_mismatch;
        t_guard;
        t_badpi;
        end_sim;
    end
    // Watchdog, far beyond the roughly 160 cycles the tests take
    initial begin
        #(4000 * 50);
        mismatches++;
        end_sim;
    end
endmodule : cmpx_top_bench
